/* src/bto_defines.vh */
`ifndef BTO_DEFINES_VH
`define BTO_DEFINES_VH
// ==========================================================
// Opcode fields
`define BTO_INVERT_TOP 4'h7
`define BTO_BRANCH_HIGH 8'he4
`define BTO_OP_TOP_MSB 15
`define BTO_OP_TOP_LSB 12
`define BTO_BIT_MSB 11
`define BTO_BIT_LSB 9
`define BTO_ACCESS_BIT 8
`define BTO_FILE_MSB 7
`define BTO_FILE_LSB 0
// ==========================================================
// Addressing
`define BTO_INDEXED_LIMIT 8'h5f
`define BTO_ACCESS_SPLIT 8'h60
`define BTO_ACCESS_HIGH_BANK 4'hf
// ==========================================================
// Quarter phases, counter step and reset values
`define BTO_Q1 2'h0
`define BTO_Q2 2'h1
`define BTO_Q3 2'h2
`define BTO_Q4 2'h3
`define BTO_PC_STEP 21'h00_0002
`define BTO_RESET_PC 21'h00_0000
`endif

/* src/bto_bit_flip.v */
`timescale 1ns/10ps
// ==========================================================
// Single-bit inversion of one data byte
module bto_bit_flip (
  // Data in and selector
  input wire [7:0] byte_in,
  input wire [2:0] bit_sel_in,
  // Modified byte
  output wire [7:0] byte_out
);
  // Mask keeps the other seven bits untouched
  assign byte_out = byte_in ^ (8'h01 << bit_sel_in);
endmodule

/* src/bto_core.v */
`timescale 1ns/10ps
// ==========================================================
`include "bto_defines.vh"
module bto_core (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // Instruction word, held for a whole cycle from Q1
  input wire [15:0] instr_in,
  input wire instr_valid_in,
  // Core state
  input wire [20:0] pc_in,
  input wire [3:0] bank_select_register_in,
  input wire [11:0] fsr2_in,
  input wire extended_set_in,
  input wire overflow_flag_in,
  // Data memory read and write ports
  input wire [7:0] mem_rdata_in,
  output reg [11:0] mem_addr_out,
  output reg mem_rd_out,
  output reg mem_wr_out,
  output reg [7:0] mem_wdata_out,
  // Program counter load
  output reg pc_load_out,
  output reg [20:0] pc_target_out,
  // Pipeline status
  output reg [1:0] quarter_out,
  output reg flush_out,
  output reg bit_invert_op_out,
  output reg branch_on_overflow_op_out,
  output wire flags_write_out
);
  // ========================================================
  // Quarter-phase sequencer
  // Each clock edge closes one quarter; four edges make a cycle
  // Counter free-runs from reset, so the first edge after release
  // is always the Q1 decode edge
  reg [1:0] q_q;
  reg [1:0] q_d;
  reg flush_q;
  reg flush_d;
  reg inv_q;
  reg inv_d;
  reg bov_q;
  reg bov_d;
  reg [7:0] data_q;
  reg [7:0] data_d;
  reg [11:0] addr_d;
  reg [20:0] tgt_q;
  reg [20:0] tgt_d;
  reg taken_q;
  reg taken_d;
  wire [7:0] flipped;
  wire is_inv;
  wire is_bov;
  wire [7:0] file_addr;
  wire [20:0] offset_x2;

  // Neither operation updates status flags
  // Flags are owned elsewhere; this output port only tells their owner so
  assign flags_write_out = 1'b0;

  // ========================================================
  // Instruction decode
  // Decoder; a flushed cycle decodes nothing
  // Gating stops the discarded word starting a read or a branch
  // Opcodes matched on their fixed bits only; the rest are operands
  assign is_inv = instr_valid_in && !flush_q &&
    (instr_in[`BTO_OP_TOP_MSB:`BTO_OP_TOP_LSB] == `BTO_INVERT_TOP);
  assign is_bov = instr_valid_in && !flush_q &&
    (instr_in[15:8] == `BTO_BRANCH_HIGH);
  assign file_addr = instr_in[`BTO_FILE_MSB:`BTO_FILE_LSB];

  // Sign-extend and double the offset
  assign offset_x2 = {{12{instr_in[7]}}, instr_in[7:0], 1'b0};

  // Modifier is pure logic so Q3 can finish in one quarter
  bto_bit_flip u_flip (
    .byte_in(data_q),
    .bit_sel_in(instr_in[`BTO_BIT_MSB:`BTO_BIT_LSB]),
    .byte_out(flipped)
  );

  // ========================================================
  // Effective address of the bit invert operand
  // Indexed sum wraps at 12 bits; no range check on the result
  // Access bank: low part in bank 0, upper part in the top bank
  always @* begin
    if (instr_in[`BTO_ACCESS_BIT]) begin
      addr_d = {bank_select_register_in, file_addr};
    end else if (extended_set_in && file_addr <= `BTO_INDEXED_LIMIT) begin
      addr_d = fsr2_in + {4'h0, file_addr};
    end else if (file_addr < `BTO_ACCESS_SPLIT) begin
      addr_d = {4'h0, file_addr};
    end else begin
      addr_d = {`BTO_ACCESS_HIGH_BANK, file_addr};
    end
  end

  // ========================================================
  // Next-state logic per quarter
  always @* begin
    q_d = q_q + 2'h1;
    flush_d = flush_q;
    inv_d = inv_q;
    bov_d = bov_q;
    data_d = data_q;
    tgt_d = tgt_q;
    taken_d = taken_q;
    case (q_q)
      `BTO_Q1: begin
        // Decode
        inv_d = is_inv;
        bov_d = is_bov;
        taken_d = 1'b0;
      end
      `BTO_Q2: begin
        // Read operand for bit invert; branch does nothing here
        // Byte taken at the end of Q2, while the read strobe stands
        if (inv_q) begin
          data_d = mem_rdata_in;
        end
      end
      `BTO_Q3: begin
        // Process: invert or compute target
        // Overflow looked at once, here; later changes are ignored
        if (inv_q) begin
          data_d = flipped;
        end
        if (bov_q) begin
          tgt_d = pc_in + `BTO_PC_STEP + offset_x2;
          taken_d = overflow_flag_in;
        end
      end
      `BTO_Q4: begin
        // Taken branch turns the next cycle into a bubble
        // One bubble only: the flushed decode clears bov_q,
        // so this term is low at the end of the bubble
        flush_d = bov_q && taken_q;
      end
      default: begin
        q_d = `BTO_Q1;
      end
    endcase
  end

  // ========================================================
  // State registers
  // Operand byte and target hold between operations
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_q <= `BTO_Q1;
      flush_q <= 1'b0;
      inv_q <= 1'b0;
      bov_q <= 1'b0;
      data_q <= 8'h00;
      tgt_q <= `BTO_RESET_PC;
      taken_q <= 1'b0;
    end else begin
      q_q <= q_d;
      flush_q <= flush_d;
      inv_q <= inv_d;
      bov_q <= bov_d;
      data_q <= data_d;
      tgt_q <= tgt_d;
      taken_q <= taken_d;
    end
  end

  // ========================================================
  // Registered outputs, each valid during the named quarter
  // Strobes are one clock wide; the memory must take single pulses
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_addr_out <= 12'h000;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
      pc_load_out <= 1'b0;
      pc_target_out <= `BTO_RESET_PC;
      quarter_out <= `BTO_Q1;
      flush_out <= 1'b0;
      bit_invert_op_out <= 1'b0;
      branch_on_overflow_op_out <= 1'b0;
    end else begin
      quarter_out <= q_d;
      flush_out <= flush_d;
      bit_invert_op_out <= inv_d;
      branch_on_overflow_op_out <= bov_d;
      // Read strobe during Q2
      mem_rd_out <= (q_q == `BTO_Q1) && is_inv;
      if (q_q == `BTO_Q1) begin
        mem_addr_out <= addr_d;
      end
      // Write-back during Q4
      mem_wr_out <= (q_q == `BTO_Q3) && inv_q;
      if (q_q == `BTO_Q3 && inv_q) begin
        mem_wdata_out <= flipped;
      end
      // Counter load in Q4 only when taken; untaken never loads
      // Untaken branch leaves the counter to its normal increment
      pc_load_out <= (q_q == `BTO_Q3) && bov_q && taken_d;
      if (q_q == `BTO_Q3 && bov_q) begin
        pc_target_out <= tgt_d;
      end
    end
  end
endmodule

/* dv/bto_core_monitor.sv */
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of strobe timing and data
module bto_core_monitor (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // Watched ports
  input wire [15:0] instr_in,
  input wire [20:0] pc_in,
  input wire [3:0] bank_select_register_in,
  input wire [11:0] fsr2_in,
  input wire extended_set_in,
  input wire overflow_flag_in,
  input wire [7:0] mem_rdata_in,
  input wire [11:0] mem_addr_out,
  input wire mem_rd_out,
  input wire mem_wr_out,
  input wire [7:0] mem_wdata_out,
  input wire pc_load_out,
  input wire [20:0] pc_target_out,
  input wire [1:0] quarter_out,
  input wire flush_out,
  input wire flags_write_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // File address and indexed-mode select of the held word
  wire [7:0] f = instr_in[7:0];
  wire idx = extended_set_in && !instr_in[8] && f <= 8'h5f;
  rd_then_wr_a: assert property (mem_rd_out |-> quarter_out == 2'h1 ##2
    mem_wr_out) else $error("read not followed by write");
  wr_quarter_a: assert property (mem_wr_out |-> quarter_out == 2'h3 &&
    !flush_out) else $error("write out of place");
  one_bit_a: assert property (mem_wr_out |-> (mem_wdata_out ^
    $past(mem_rdata_in, 2)) == (8'h01 << instr_in[11:9])) else $error("flip");
  bank_addr_a: assert property (mem_rd_out && instr_in[8] |->
    mem_addr_out == {bank_select_register_in, f}) else $error("bank");
  access_addr_a: assert property (mem_rd_out && !instr_in[8] && !idx |->
    mem_addr_out == {(f < 8'h60 ? 4'h0 : 4'hf), f}) else $error("access");
  index_addr_a: assert property (mem_rd_out && idx |->
    mem_addr_out == fsr2_in + {4'h0, f}) else $error("indexed");
  branch_tgt_a: assert property (pc_load_out |-> overflow_flag_in &&
    quarter_out == 2'h3 && pc_target_out == pc_in + 21'h00_0002 +
    {{12{f[7]}}, f, 1'b0}) else $error("branch target");
  flush_len_a: assert property (pc_load_out |=> flush_out [*4]
    ##1 !flush_out) else $error("flush length");
  no_flags_a: assert property (!flags_write_out) else $error("flag write");
  flush_quiet_a: assert property (flush_out |-> !mem_rd_out &&
    !mem_wr_out && !pc_load_out) else $error("strobe while flushed");
  // Main scenarios reached
  cover property (mem_wr_out);
  cover property (pc_load_out);
  cover property (mem_rd_out && idx);
endmodule
bind bto_core bto_core_monitor mon (.core_clk_in, .rstn_in, .instr_in,
  .pc_in, .bank_select_register_in, .fsr2_in, .extended_set_in,
  .overflow_flag_in, .mem_rdata_in, .mem_addr_out, .mem_rd_out, .mem_wr_out,
  .mem_wdata_out, .pc_load_out, .pc_target_out, .quarter_out, .flush_out,
  .flags_write_out);

/* dv/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %0t check %0d", $time, checked); end end
module tb_top;
  typedef struct {logic [15:0] i; logic [7:0] r; logic o, x;
    logic [11:0] a; logic [7:0] w; logic [20:0] t;} bto_row_t;
  reg core_clk_in = 1'b0, rstn_in = 1'b0, ovf = 1'b0, ext = 1'b0;
  reg [15:0] ins = 16'h0000;
  reg [7:0] rdata = 8'h00;
  wire [11:0] addr;
  wire rd, wr, ld, fl, iv, bv;
  wire [7:0] wd;
  wire [20:0] tgt;
  int n_mismatch = 0, checked = 0;
  // ==========================================================
  // Word, read byte, overflow, extended, address, write, target
  bto_row_t rows[11] = '{'{16'h7880, 8'h75, 1, 0, 12'hf80, 8'h65, 0},
    '{16'h7f10, 8'h00, 0, 0, 12'h510, 8'h80, 0},
    '{16'h705f, 8'hff, 0, 1, 12'h15f, 8'hfe, 0},
    '{16'h7460, 8'h0f, 0, 1, 12'hf60, 8'h0b, 0},
    '{16'h7205, 8'haa, 0, 0, 12'h005, 8'ha8, 0},
    '{16'h7d20, 8'h40, 0, 1, 12'h520, 8'h00, 0},
    '{16'he47f, 8'h00, 1, 0, 0, 0, 21'h00_1100},
    '{16'he480, 8'h00, 1, 0, 0, 0, 21'h00_0f02},
    '{16'he405, 8'h00, 0, 0, 0, 0, 0},
    '{16'he080, 8'h00, 1, 0, 0, 0, 0},
    '{16'h6880, 8'h75, 1, 0, 0, 0, 0}};
  bto_core dut (.core_clk_in, .rstn_in, .instr_in(ins), .instr_valid_in(1'b1),
    .pc_in(21'h00_1000), .bank_select_register_in(4'h5), .fsr2_in(12'h100),
    .extended_set_in(ext), .overflow_flag_in(ovf), .mem_rdata_in(rdata),
    .mem_addr_out(addr), .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wd),
    .pc_load_out(ld), .pc_target_out(tgt), .quarter_out(), .flush_out(fl),
    .bit_invert_op_out(iv), .branch_on_overflow_op_out(bv),
    .flags_write_out());
  // One quarter per edge, 5 ns period
  initial forever #2.5 core_clk_in = ~core_clk_in;
  // One instruction slot; sampled mid-quarter so edge updates have landed
  task slot(input bto_row_t r);
    logic bt, br, tk;
    begin
      bt = r.i[15:12] == 4'h7;
      br = r.i[15:8] == 8'he4;
      tk = br && r.o;
      ins <= r.i; rdata <= r.r; ovf <= r.o; ext <= r.x;
      for (int k = 0; k < 4; k++) begin
        @(negedge core_clk_in);
        if (k == 1) `CHK({rd, bt ? addr : 12'h000}, {bt, r.a})
        if (k == 1) `CHK({fl, iv, bv}, {1'b0, bt, br})
        if (k == 3) `CHK({wr, bt ? wd : 8'h00}, {bt, r.w})
        if (k == 3) `CHK({ld, tk ? tgt : 21'h00_0000}, {tk, r.t})
        @(posedge core_clk_in);
      end
      // Word fetched during a taken branch must be dropped
      if (tk) begin
        ins <= 16'h7880;
        repeat (4) begin
          @(negedge core_clk_in);
          `CHK({fl, rd, wr}, 3'h4)
          @(posedge core_clk_in);
        end
      end
    end
  endtask
  task end_sim;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Table run, then reset in mid-instruction
  initial begin
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    foreach (rows[n]) slot(rows[n]);
    ins <= 16'he47f;
    @(posedge core_clk_in);
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    @(negedge core_clk_in);
    `CHK({rd, wr, ld, fl}, 4'h0)
    @(posedge core_clk_in);
    rstn_in <= 1'b1;
    slot(rows[0]);
    end_sim;
  end
  // Hang guard, well past the expected run
  initial begin
    #3000;
    n_mismatch++;
    end_sim;
  end
endmodule
